// ===== pacer_params.svh
`ifndef PACER_PARAMS_SVH
`define PACER_PARAMS_SVH

// Byte offsets above the card base address
`define PACER_OFS_COUNTER0 8'hC0
`define PACER_OFS_COUNTER1 8'hC4
`define PACER_OFS_COUNTER2 8'hC8
`define PACER_OFS_CONTROL 8'hCC

// Control word fields
`define PACER_CW_SEL_HI 7
`define PACER_CW_SEL_LO 6
`define PACER_CW_PERIODIC 0
`define PACER_CW_SEL_NONE 2'h3

// Clocking
`define PACER_CORE_CLK_HZ 100000000
`define PACER_INT_CLK_HZ 2000000
`define PACER_EXT_CLK_MAX_HZ 10000000
`define PACER_DIV_COUNT (`PACER_CORE_CLK_HZ / `PACER_INT_CLK_HZ)

// Reset values
`define PACER_RST_BYTE 8'h00
`define PACER_RST_COUNT 16'h0000

`endif

// ===== pacer_pkg.sv
`default_nettype none

package pacer_pkg;

  typedef logic [15:0] count_t;
  typedef logic [7:0] byte_t;

  typedef struct packed {
    count_t count;
    count_t reload;
    logic run;
    logic periodic;
    logic out;
    logic tc;
  } unit_s;

  typedef struct packed {
    logic [2:0] wr_hi;
    logic [2:0] rd_hi;
    logic [2:0][7:0] lo_byte;
    logic [2:0] periodic;
    logic [2:0] load;
    logic [2:0] stop;
    count_t load_val;
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic [2:0] ext0_s;
    logic [2:0] ext1_s;
    logic [5:0] div_cnt;
    logic int_tick;
    byte_t rdata;
    logic rvalid;
    logic [2:0] cout;
    logic pacer;
    logic diff_mode;
  } top_s;

endpackage : pacer_pkg

`default_nettype wire

// ===== pace_counter16.sv
`timescale 1ns/1ps
`default_nettype none

module pace_counter16 (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Control
  input wire logic tick_i,
  input wire logic gate_i,
  input wire logic load_i,
  input wire logic stop_i,
  input wire logic periodic_i,
  input wire pacer_pkg::count_t load_val_i,
  // Status
  output pacer_pkg::count_t count_o,
  output logic out_o,
  output logic tc_o
);
  import pacer_pkg::*;

  unit_s q;
  unit_s d;

  always_comb begin
    d = q;
    d.tc = 1'b0;
    if (stop_i) begin
      d.run = 1'b0;
      d.out = 1'b0;
    end else if (load_i) begin
      d.count = load_val_i;
      d.reload = load_val_i;
      d.periodic = periodic_i;
      d.run = 1'b1;
    end else if (tick_i && gate_i && q.run) begin
      // A loaded zero counts the full 65536 states
      if (q.count == 16'h0001) begin
        d.tc = 1'b1;
        d.out = ~q.out;
        d.count = q.reload;
        d.run = q.periodic;
      end else begin
        d.count = q.count - 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count_o = q.count;
  assign out_o = q.out;
  assign tc_o = q.tc;

endmodule : pace_counter16

`default_nettype wire

// ===== pacer_timer_counter_config.sv
// What this block does
// - Three independent 16-bit counters, numbered zero to two.
// - Counters zero and two chain into one 32-bit timer.
// - Four host registers span base plus 0xC0 through base plus 0xCC.
// - Counter zero clock is internal 2 MHz or external pin, by jumper.
// - Counter two gate is external pin or counter zero output; pin default.
// - All analog inputs share one mode: 16 single-ended or 8 differential.
// - With no jumper fitted the analog inputs are single-ended.
// - Counter two paces conversions; counters zero and one stay general.
`timescale 1ns/1ps
`default_nettype none

`include "pacer_params.svh"

module pacer_timer_counter_config #(
  parameter int unsigned DIV_COUNT = `PACER_DIV_COUNT
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Host register access, 8-bit data
  input wire logic [7:0] host_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire pacer_pkg::byte_t host_wdata_i,
  output pacer_pkg::byte_t host_rdata_o,
  output logic host_rvalid_o,
  // Board pins and jumpers
  input wire logic ext_clk0_i,
  input wire logic ext_clk1_i,
  input wire logic ext_gate2_i,
  input wire logic timer0_clock_select_jumper_i,
  input wire logic counter2_gate_select_jumper_i,
  input wire logic input_type_select_jumper_i,
  input wire logic cascade_select_i,
  // Timer outputs
  output logic [2:0] counter_out_o,
  output logic pacer_trigger_o,
  // Analog input mode, high for differential
  output logic diff_mode_o
);
  import pacer_pkg::*;

  if (DIV_COUNT < 2 || DIV_COUNT > 64) begin : g_div_check
    $error("DIV_COUNT must lie between 2 and 64");
  end

  if (`PACER_CW_SEL_HI != `PACER_CW_SEL_LO + 1) begin : g_sel_check
    $error("Counter select field must be two bits wide");
  end

  if (`PACER_OFS_COUNTER1 - `PACER_OFS_COUNTER0 != 8'h04) begin : g_stride_check
    $error("Counter registers must sit four bytes apart");
  end

  localparam logic [5:0] DIV_LAST = 6'(DIV_COUNT - 1);

  top_s q;
  top_s d;
  count_t cnt [3];
  logic [2:0] unit_out;
  logic [2:0] unit_tc;
  logic [2:0] tick;
  logic [2:0] gate;

  // Returns {hit, index}; index 3 is the control word
  function automatic logic [2:0] decode_ofs(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h0;
    unique case (a)
      `PACER_OFS_COUNTER0: r = 3'h4;
      `PACER_OFS_COUNTER1: r = 3'h5;
      `PACER_OFS_COUNTER2: r = 3'h6;
      `PACER_OFS_CONTROL: r = 3'h7;
      default: r = 3'h0;
    endcase
    return r;
  endfunction : decode_ofs

  // Rising edge seen between the second and third stages of a pin chain
  function automatic logic rise_of(input logic [2:0] s);
    return s[1] & ~s[2];
  endfunction : rise_of

  // Byte of a count picked by the read pointer
  function automatic byte_t count_byte(input count_t c, input logic hi);
    return hi ? c[15:8] : c[7:0];
  endfunction : count_byte

  // Synchronised pin order: clk sel, gate sel, input type, gate pin, cascade
  logic clk0_ext_sel;
  logic gate2_cout_sel;
  logic gate2_pin;
  logic cascade_on;
  logic ext0_rise;
  logic ext1_rise;

  always_comb begin
    clk0_ext_sel = q.pin_s2[0];
    gate2_cout_sel = q.pin_s2[1];
    gate2_pin = q.pin_s2[3];
    cascade_on = q.pin_s2[4];
    // Edges come from the second and third stages only
    ext0_rise = rise_of(q.ext0_s);
    ext1_rise = rise_of(q.ext1_s);
    // Sampling at 100 MHz resolves an external clock up to 10 MHz
    tick[0] = clk0_ext_sel ? ext0_rise : q.int_tick;
    tick[1] = ext1_rise;
    // Chained: counter two counts counter zero terminal counts
    tick[2] = cascade_on ? unit_tc[0] : q.int_tick;
    // Only counter two has a gate; the others always count
    gate[0] = 1'b1;
    gate[1] = 1'b1;
    gate[2] = gate2_cout_sel ? unit_out[0] : gate2_pin;
  end

  // Host strobe decode, kept apart so each path below reads plainly
  logic [2:0] hit;
  logic [1:0] idx;
  logic [1:0] sel;
  logic wr_ctrl;
  logic wr_lo_byte;
  logic wr_hi_byte;
  logic rd_count;
  byte_t rd_byte;

  always_comb begin
    hit = decode_ofs(host_addr_i);
    idx = hit[1:0];
    sel = host_wdata_i[`PACER_CW_SEL_HI:`PACER_CW_SEL_LO];
    // Index three is the control word and never a counter
    wr_ctrl = host_wr_i && hit[2] && idx == 2'h3;
    wr_lo_byte = host_wr_i && hit[2] && idx != 2'h3 && !q.wr_hi[idx];
    wr_hi_byte = host_wr_i && hit[2] && idx != 2'h3 && q.wr_hi[idx];
    rd_count = host_rd_i && hit[2] && idx != 2'h3;
    // Control word is write-only; unmapped reads return zero
    rd_byte = `PACER_RST_BYTE;
    if (rd_count) begin
      rd_byte = count_byte(cnt[idx], q.rd_hi[idx]);
    end
  end

  always_comb begin
    d = q;
    d.load = 3'h0;
    d.stop = 3'h0;
    d.rvalid = 1'b0;
    d.pin_s1 = {cascade_select_i, ext_gate2_i, input_type_select_jumper_i,
                counter2_gate_select_jumper_i, timer0_clock_select_jumper_i};
    d.pin_s2 = q.pin_s1;
    d.ext0_s = {q.ext0_s[1:0], ext_clk0_i};
    d.ext1_s = {q.ext1_s[1:0], ext_clk1_i};
    // Internal 2 MHz reference as a one-cycle enable
    d.int_tick = (q.div_cnt == DIV_LAST);
    d.div_cnt = d.int_tick ? 6'h00 : q.div_cnt + 6'h01;
    if (wr_ctrl && sel != `PACER_CW_SEL_NONE) begin
      // Control word restarts byte order and stops the chosen counter
      d.wr_hi[sel] = 1'b0;
      d.rd_hi[sel] = 1'b0;
      d.periodic[sel] = host_wdata_i[`PACER_CW_PERIODIC];
      d.stop[sel] = 1'b1;
    end
    if (wr_lo_byte) begin
      d.lo_byte[idx] = host_wdata_i;
      d.wr_hi[idx] = 1'b1;
    end
    if (wr_hi_byte) begin
      // One shared load word is safe: only one byte write lands per cycle
      d.load_val = {host_wdata_i, q.lo_byte[idx]};
      d.load[idx] = 1'b1;
      d.wr_hi[idx] = 1'b0;
    end
    if (host_rd_i) begin
      d.rvalid = 1'b1;
      d.rdata = rd_byte;
    end
    if (rd_count) begin
      // Live count, no latch: a count moving between bytes can tear
      d.rd_hi[idx] = ~q.rd_hi[idx];
    end
    d.cout = unit_out;
    d.pacer = unit_tc[2];
    // One jumper sets every channel; open jumper means single-ended
    d.diff_mode = q.pin_s2[2];
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_unit
    pace_counter16 u_cnt (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .tick_i(tick[i]),
      .gate_i(gate[i]),
      .load_i(q.load[i]),
      .stop_i(q.stop[i]),
      .periodic_i(q.periodic[i]),
      .load_val_i(q.load_val),
      .count_o(cnt[i]),
      .out_o(unit_out[i]),
      .tc_o(unit_tc[i])
    );
  end

  assign host_rdata_o = q.rdata;
  assign host_rvalid_o = q.rvalid;
  assign counter_out_o = q.cout;
  assign pacer_trigger_o = q.pacer;
  assign diff_mode_o = q.diff_mode;

endmodule : pacer_timer_counter_config

`default_nettype wire

// ===== pacer_props.sv
`timescale 1ns/1ps
`default_nettype none
module pacer_props (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] host_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire pacer_pkg::byte_t host_wdata_i,
  input wire pacer_pkg::byte_t host_rdata_o,
  input wire logic host_rvalid_o,
  input wire logic input_type_select_jumper_i,
  input wire logic [2:0] counter_out_o,
  input wire logic pacer_trigger_o,
  input wire logic diff_mode_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_read_answer: assert property (host_rd_i |=> host_rvalid_o)
    else $error("no answer");
  a_answer_cause: assert property (host_rvalid_o |-> $past(host_rd_i))
    else $error("stray answer");
  a_write_silent: assert property (host_wr_i && !host_rd_i |=> !host_rvalid_o)
    else $error("write answered");
  a_rdata_hold: assert property (!host_rvalid_o |-> $stable(host_rdata_o))
    else $error("rdata moved");
  a_unmapped_zero: assert property (
    host_rd_i && !(host_addr_i inside {8'hC0, 8'hC4, 8'hC8}) |=> host_rdata_o == 8'h00)
    else $error("unmapped data");
  a_mode_follow: assert property ($stable(input_type_select_jumper_i) [*6]
    |-> diff_mode_o == input_type_select_jumper_i) else $error("mode lag");
  a_pacer_pulse: assert property (pacer_trigger_o |=> !pacer_trigger_o)
    else $error("long pulse");
  a_pacer_toggle: assert property ($rose(pacer_trigger_o)
    |-> ##[0:1] counter_out_o[2] != $past(counter_out_o[2], 2)) else $error("no toggle");
  a_ctrl_stop: assert property (
    host_wr_i && host_addr_i == 8'hCC && host_wdata_i[7:6] == 2'h0 |-> ##[1:3] !counter_out_o[0])
    else $error("no stop");
endmodule : pacer_props
bind pacer_timer_counter_config pacer_props i_props (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .host_addr_i(host_addr_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
  .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
  .input_type_select_jumper_i(input_type_select_jumper_i), .counter_out_o(counter_out_o),
  .pacer_trigger_o(pacer_trigger_o), .diff_mode_o(diff_mode_o));
`default_nettype wire

// ===== pacer_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pacer_host_model (
  // Clock
  input wire logic core_clk_i,
  // Answer from the block
  input wire pacer_pkg::byte_t rdata_i,
  input wire logic rvalid_i,
  // Requests
  output logic [7:0] addr_o,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output pacer_pkg::byte_t wdata_o = 8'h00
);
  import pacer_pkg::*;
  initial addr_o = 8'h00;
  task automatic put(input logic [7:0] a, input byte_t d);
    @(posedge core_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge core_clk_i);
    wr_o <= 1'b0;
    // Released data never repeats the old byte
    wdata_o <= ~d;
  endtask : put
  task automatic get(input logic [7:0] a, output byte_t d);
    @(posedge core_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge core_clk_i);
    rd_o <= 1'b0;
    @(posedge core_clk_i);
    d = rvalid_i ? rdata_i : 8'hXX;
  endtask : get
  // One owner per counter: each load rewrites control first
  task automatic prog(input logic [1:0] sel, input logic per, input logic [15:0] v);
    put(8'hCC, {sel, 5'h00, per});
    put(8'hC0 + {4'h0, sel, 2'h0}, v[7:0]);
    put(8'hC0 + {4'h0, sel, 2'h0}, v[15:8]);
  endtask : prog
endmodule : pacer_host_model
`default_nettype wire

// ===== tb_pacer_timer_counter_config.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pacer_timer_counter_config;
  import pacer_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr;
  logic wr, rd, rv, pacer, diff, gate = 1'b0, casc = 1'b0;
  logic [1:0] ext = 2'h0;
  logic [2:0] jmp = 3'h0;
  logic [2:0] cout;
  byte_t wd, rdat, lo, hi;
  int miscompares = 0;
  int checks = 0;
  always #5 core_clk_i = ~core_clk_i;
  pacer_host_model i_host (.core_clk_i(core_clk_i), .rdata_i(rdat), .rvalid_i(rv),
    .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wd));
  // Short divider keeps pacer periods to a few cycles
  pacer_timer_counter_config #(.DIV_COUNT(2)) i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .host_addr_i(addr), .host_wr_i(wr), .host_rd_i(rd), .host_wdata_i(wd),
    .host_rdata_o(rdat), .host_rvalid_o(rv), .ext_clk0_i(ext[0]), .ext_clk1_i(ext[1]),
    .ext_gate2_i(gate), .timer0_clock_select_jumper_i(jmp[0]),
    .counter2_gate_select_jumper_i(jmp[1]), .input_type_select_jumper_i(jmp[2]),
    .cascade_select_i(casc), .counter_out_o(cout), .pacer_trigger_o(pacer),
    .diff_mode_o(diff));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results;
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic t_mode;
    for (int v = 1; v >= 0; v--) begin
      @(posedge core_clk_i);
      jmp[2] <= v[0];
      repeat (6) @(posedge core_clk_i);
      check("diff mode", {15'h0, diff}, v[15:0]);
    end
  endtask : t_mode
  // Slow edges hold the outside clock at its 10 MHz ceiling
  task automatic t_ext(input logic [1:0] sel);
    jmp[0] <= 1'b1;
    i_host.prog(sel, 1'b0, 16'h1234);
    repeat (3) begin
      repeat (5) @(posedge core_clk_i);
      ext[sel[0]] <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      ext[sel[0]] <= 1'b0;
    end
    repeat (6) @(posedge core_clk_i);
    i_host.get(8'hC0 + {4'h0, sel, 2'h0}, lo);
    i_host.get(8'hC0 + {4'h0, sel, 2'h0}, hi);
    check("ext count", {hi, lo}, 16'h1231);
  endtask : t_ext
  task automatic gap(input int exp);
    int n;
    logic was;
    was = 1'b0;
    for (int k = 0; k < 2; k++) begin
      was = cout[2];
      n = 0;
      do @(posedge core_clk_i); while (pacer !== 1'b1 && ++n < 200);
    end
    check("pacer gap", 16'(n + 1), 16'(exp));
    check("pacer out", {15'h0, cout[2]}, {15'h0, ~was});
  endtask : gap
  task automatic quiet;
    int n;
    n = 0;
    repeat (40) begin
      @(posedge core_clk_i);
      if (pacer === 1'b1) n++;
    end
    check("gated pacer", 16'(n), 16'h0000);
  endtask : quiet
  initial begin
    #100000;
    miscompares++;
    results();
  end
  task automatic t_reset;
    @(posedge core_clk_i);
    check("reset outs", {12'h0, cout, pacer, diff}, 16'h0000);
  endtask : t_reset
  task automatic t_unmapped;
    i_host.get(8'hCC, lo);
    i_host.get(8'hD0, hi);
    check("unmapped", {hi, lo}, 16'h0000);
  endtask : t_unmapped
  // Pin gate paces, then a low pin gate stops it, and so does the counter zero output gate (low) with the pin high
  task automatic t_gate;
    gate <= 1'b1;
    i_host.prog(2'h2, 1'b1, 16'h0003);
    gap(6);
    gate <= 1'b0;
    quiet();
    gate <= 1'b1;
    jmp[1] <= 1'b1;
    quiet();
  endtask : t_gate
  task automatic t_cascade;
    jmp[1:0] <= 2'h0;
    casc <= 1'b1;
    i_host.prog(2'h0, 1'b1, 16'h0002);
    i_host.prog(2'h2, 1'b1, 16'h0002);
    // No-counter select must leave the chain running
    i_host.put(8'hCC, 8'hC0);
    gap(8);
  endtask : t_cascade
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_mode();
    t_ext(2'h0);
    t_ext(2'h1);
    t_unmapped();
    t_gate();
    t_cascade();
    results();
  end
endmodule : tb_pacer_timer_counter_config
`default_nettype wire
